// File: awmr_pkg.sv
package awmr_pkg;
  // Register addresses in special-function register space
  localparam logic [7:0] ADDR_UPPER_LOW = 8'hC3;
  localparam logic [7:0] ADDR_UPPER_HIGH = 8'hC4;
  localparam logic [7:0] ADDR_LOWER_LOW = 8'hC5;
  localparam logic [7:0] ADDR_LOWER_HIGH = 8'hC6;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hBD;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBE;
  localparam logic [7:0] ADDR_POS_SEL = 8'hBB;
  localparam logic [7:0] ADDR_NEG_SEL = 8'hBA;
  localparam logic [7:0] ADDR_REF_CTRL = 8'hD1;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'hE8;
  // Reset values
  localparam logic [7:0] RST_UPPER = 8'hFF;
  localparam logic [7:0] RST_LOWER = 8'h00;
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_REF = 8'h00;
  // Field positions
  localparam int SEL_W = 6;
  localparam int REF_GAIN_BIT = 7;
  localparam int REF_OVR_BIT = 4;
  localparam int REF_SRC_BIT = 3;
  localparam int REF_TEMP_BIT = 2;
  localparam int REF_BIAS_BIT = 1;
  localparam int REF_DRIVE_BIT = 0;
  localparam int CTRL_WIN_BIT = 3;
  localparam logic [7:0] REF_WMASK = 8'h9F;
  // Input select codes
  localparam logic [5:0] POS_TEMP = 6'h1E;
  localparam logic [5:0] POS_SUPPLY = 6'h1F;
  localparam logic [5:0] NEG_REFPIN = 6'h1E;
  localparam logic [5:0] NEG_GROUND = 6'h1F;
  localparam logic [5:0] SEL_RSVD_MIN = 6'h23;
  // Reference source encoding
  typedef enum logic [1:0] {AWMR_REF_PIN, AWMR_REF_SUPPLY, AWMR_REF_REGULATOR} awmr_ref_t;
endpackage : awmr_pkg

// File: awmr_control.sv
`timescale 1ns/100ps
// Summary of operation
// R1 - Result is unsigned 10-bit, compared in window
// R2 - Inside window: greater-than < word < less-than
// R3 - Outside window: word below or above bounds
// R4 - Limit values alone choose inside or outside
// R5 - Lower-limit low byte read/write, resets zero
// R6 - Compare justified word once per conversion
// R7 - Positive select: temp 011110, supply 011111
// R8 - Negative select: refpin 011110, ground 011111
// R9 - Ground negative input means single-ended mode
// R10 - Select upper two bits read zero
// R11 - Source bit: 0 ref pin, 1 supply
// R12 - Override bit forces regulated supply reference
// R13 - Bias on by peripheral demand or force
// R14 - Reference buffer gain 1x or 2x
// R15 - Gain bit 0 is 2x, 1 is 1x
// R16 - Drive reference pin only when bit set
// R17 - Software clears drive bit when unused
module awmr_control
  import awmr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Converter core
  input wire logic conv_done,
  input wire logic [9:0] conv_word,
  input wire logic left_justify,
  input wire logic bias_demand,
  // Window detector
  output logic window_match_flag,
  // Multiplexer and reference controls
  output logic [5:0] pos_sel_out,
  output logic [5:0] neg_sel_out,
  output logic pos_temp_sensor,
  output logic pos_supply,
  output logic pos_reserved,
  output logic neg_refpin,
  output logic neg_reserved,
  output logic single_ended,
  output awmr_ref_t ref_source,
  output logic bias_enable,
  output logic temp_sensor_enable,
  output logic ref_gain_2x,
  output logic ref_pin_drive
);

  // Justify the 10-bit word into the 16-bit result layout
  function automatic logic [15:0] justify(input logic [9:0] w, input logic lj);
    if (lj) begin
      justify = {w, 6'b00_0000};
    end else begin
      justify = {6'b00_0000, w};
    end
  endfunction : justify

  // Register state
  logic [7:0] upper_limit_high_byte, upper_limit_low_byte; // Greater-than pair
  logic [7:0] lower_limit_high_byte, lower_limit_low_byte; // Less-than pair
  logic [15:0] result; // Latest justified word
  logic [5:0] positive_input_select, negative_input_select;
  logic [7:0] reference_control;
  logic flag;
  // Next values
  logic [7:0] next_uh, next_ul, next_lh, next_ll, next_ref;
  logic [15:0] next_result;
  logic [5:0] next_pos, next_neg;
  logic next_flag;
  // Compare helpers
  logic [15:0] gt_lim, lt_lim, cur;
  logic inside_mode, hit;

  // Window decision for the completing conversion
  // Both limit pairs are compared as full 16-bit words, so a left-justified
  // word needs limits written in the same layout
  always_comb begin
    gt_lim = {upper_limit_high_byte, upper_limit_low_byte};
    lt_lim = {lower_limit_high_byte, lower_limit_low_byte};
    cur = justify(conv_word, left_justify); // R1 R6
    inside_mode = lt_lim > gt_lim; // R4
    if (inside_mode) begin
      hit = (cur > gt_lim) && (cur < lt_lim); // R2
    end else begin
      // Outside: below the lower bound or above the upper bound
      hit = (cur < lt_lim) || (cur > gt_lim); // R3
    end
  end

  // Register next-state logic; flag set wins over a software clear
  always_comb begin
    next_uh = upper_limit_high_byte;
    next_ul = upper_limit_low_byte;
    next_lh = lower_limit_high_byte;
    next_ll = lower_limit_low_byte;
    next_ref = reference_control;
    next_pos = positive_input_select;
    next_neg = negative_input_select;
    next_result = result;
    next_flag = flag;
    // Software writes land first; a completing conversion below may then
    // override the flag so that a match is never lost to a clear
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_UPPER_HIGH: next_uh = sfr_wdata;
        ADDR_UPPER_LOW: next_ul = sfr_wdata;
        ADDR_LOWER_HIGH: next_lh = sfr_wdata;
        ADDR_LOWER_LOW: next_ll = sfr_wdata; // R5
        ADDR_POS_SEL: next_pos = sfr_wdata[SEL_W-1:0]; // R10
        ADDR_NEG_SEL: next_neg = sfr_wdata[SEL_W-1:0]; // R10
        ADDR_REF_CTRL: next_ref = sfr_wdata & REF_WMASK;
        ADDR_CONV_CTRL: next_flag = sfr_wdata[CTRL_WIN_BIT];
        default: next_flag = flag;
      endcase
    end
    // The result is captured on every completion, hit or not
    // The flag is sticky: only software or reset takes it down again
    if (conv_done) begin
      next_result = justify(conv_word, left_justify);
      if (hit) begin
        next_flag = 1'b1; // R6
      end
    end
  end

  // State registers
  // Reset is synchronous; limits come up as an outside window that never hits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      upper_limit_high_byte <= RST_UPPER;
      upper_limit_low_byte <= RST_UPPER;
      lower_limit_high_byte <= RST_LOWER;
      lower_limit_low_byte <= RST_LOWER; // R5
      reference_control <= RST_REF;
      positive_input_select <= RST_SEL[SEL_W-1:0];
      negative_input_select <= RST_SEL[SEL_W-1:0];
      result <= 16'h0000;
      flag <= 1'b0;
    end else begin
      upper_limit_high_byte <= next_uh;
      upper_limit_low_byte <= next_ul;
      lower_limit_high_byte <= next_lh;
      lower_limit_low_byte <= next_ll;
      reference_control <= next_ref;
      positive_input_select <= next_pos;
      negative_input_select <= next_neg;
      result <= next_result;
      flag <= next_flag;
    end
  end

  // Read mux; unmapped addresses read zero
  // Reads have no side effects, so the read strobe is not needed here
  always_comb begin
    case (sfr_addr)
      ADDR_UPPER_HIGH: sfr_rdata = upper_limit_high_byte;
      ADDR_UPPER_LOW: sfr_rdata = upper_limit_low_byte;
      ADDR_LOWER_HIGH: sfr_rdata = lower_limit_high_byte;
      ADDR_LOWER_LOW: sfr_rdata = lower_limit_low_byte; // R5
      ADDR_RESULT_HIGH: sfr_rdata = result[15:8];
      ADDR_RESULT_LOW: sfr_rdata = result[7:0];
      ADDR_POS_SEL: sfr_rdata = {2'b00, positive_input_select}; // R10
      ADDR_NEG_SEL: sfr_rdata = {2'b00, negative_input_select}; // R10
      ADDR_REF_CTRL: sfr_rdata = reference_control;
      ADDR_CONV_CTRL: sfr_rdata = {4'h0, flag, 3'b000};
      default: sfr_rdata = 8'h00;
    endcase
  end

  // Analog control decode
  // All outputs but bias_enable, which also takes bias_demand, follow the registers directly; the analog side sees a change
  // one cycle after the write, with no extra settling delay imposed here
  always_comb begin
    window_match_flag = flag;
    pos_sel_out = positive_input_select;
    neg_sel_out = negative_input_select;
    pos_temp_sensor = positive_input_select == POS_TEMP; // R7
    pos_supply = positive_input_select == POS_SUPPLY; // R7
    pos_reserved = positive_input_select >= SEL_RSVD_MIN; // R7
    neg_refpin = negative_input_select == NEG_REFPIN; // R8
    neg_reserved = negative_input_select >= SEL_RSVD_MIN; // R8
    single_ended = negative_input_select == NEG_GROUND; // R8 R9
    if (reference_control[REF_OVR_BIT]) begin
      ref_source = AWMR_REF_REGULATOR; // R12
    end else if (reference_control[REF_SRC_BIT]) begin
      ref_source = AWMR_REF_SUPPLY; // R11
    end else begin
      ref_source = AWMR_REF_PIN; // R11
    end
    bias_enable = bias_demand | reference_control[REF_BIAS_BIT]; // R13
    temp_sensor_enable = reference_control[REF_TEMP_BIT];
    ref_gain_2x = ~reference_control[REF_GAIN_BIT]; // R14 R15
    ref_pin_drive = reference_control[REF_DRIVE_BIT]; // R16
  end

  // Checks
  // Window checks look at the cycle after a completion, when the flag has
  // had its one chance to be set; software writes are excluded where they
  // could mask the result
  inside_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    conv_done && inside_mode && hit |=> window_match_flag) // R2
    else $error("inside window hit lost");
  outside_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    conv_done && !inside_mode && hit |=> window_match_flag) // R3
    else $error("outside window hit lost");
  mode_pick_a: assert property (@(posedge sys_clk) disable iff (rst)
    conv_done && lt_lim > gt_lim && cur <= gt_lim && !flag && !sfr_wr |=> !flag) // R4
    else $error("inside mode flagged low word");
  flag_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !conv_done && !(sfr_wr && sfr_addr == ADDR_CONV_CTRL) |=> $stable(flag)) // R6
    else $error("flag changed without cause");
  sel_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    sfr_addr == ADDR_POS_SEL |-> sfr_rdata[7:6] == 2'b00) // R10
    else $error("select upper bits not zero");
  single_end_a: assert property (@(posedge sys_clk) disable iff (rst)
    sfr_wr && sfr_addr == ADDR_NEG_SEL && sfr_wdata[5:0] == NEG_GROUND |=> single_ended) // R9
    else $error("ground select not single ended");
  ref_ovr_a: assert property (@(posedge sys_clk) disable iff (rst)
    reference_control[REF_OVR_BIT] |-> ref_source == AWMR_REF_REGULATOR) // R12
    else $error("override ignored");
  bias_on_a: assert property (@(posedge sys_clk) disable iff (rst)
    bias_demand |-> bias_enable) // R13
    else $error("bias not on");
  gain_pol_a: assert property (@(posedge sys_clk) disable iff (rst)
    sfr_wr && sfr_addr == ADDR_REF_CTRL |=> ref_gain_2x == !$past(sfr_wdata[REF_GAIN_BIT])) // R15
    else $error("gain polarity wrong");
  drive_a: assert property (@(posedge sys_clk) disable iff (rst)
    sfr_wr && sfr_addr == ADDR_REF_CTRL |=> ref_pin_drive == $past(sfr_wdata[REF_DRIVE_BIT])) // R16
    else $error("drive bit wrong");
  lower_rst_a: assert property (@(posedge sys_clk)
    $past(rst) |-> lower_limit_low_byte == 8'h00) // R5
    else $error("lower low byte not reset");

  // A word on or above the less-than bound must not raise the flag inside a window
  inside_miss_a: assert property (@(posedge sys_clk) disable iff (rst) // R2
    conv_done && inside_mode && cur >= lt_lim && !flag && !sfr_wr |=> !flag)
    else $error("inside window miss flagged");
  // A word between the bounds must not raise the flag outside a window
  outside_miss_a: assert property (@(posedge sys_clk) disable iff (rst) // R3
    conv_done && !inside_mode && cur >= lt_lim && cur <= gt_lim && !flag && !sfr_wr |=> !flag)
    else $error("outside window miss flagged");
  // The captured result is the justified word of the completion
  result_load_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    conv_done |=> result == $past(cur))
    else $error("result not captured");
  // Software clear takes the flag down when no conversion completes
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
    sfr_wr && sfr_addr == ADDR_CONV_CTRL && !sfr_wdata[CTRL_WIN_BIT] && !conv_done |=> !flag)
    else $error("flag clear ignored");
  // A hit in the same cycle as a clear still leaves the flag set
  set_wins_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
    sfr_wr && sfr_addr == ADDR_CONV_CTRL && conv_done && hit |=> window_match_flag)
    else $error("clear beat a hit");
  // Lower-limit low byte takes the written value
  lower_write_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
    sfr_wr && sfr_addr == ADDR_LOWER_LOW |=> lower_limit_low_byte == $past(sfr_wdata))
    else $error("lower low byte write lost");
  // Temperature sensor code reaches its decode
  pos_temp_a: assert property (@(posedge sys_clk) disable iff (rst) // R7
    sfr_wr && sfr_addr == ADDR_POS_SEL && sfr_wdata[5:0] == POS_TEMP |=> pos_temp_sensor)
    else $error("temp sensor select lost");
  // Reference pin code reaches its decode
  neg_ref_a: assert property (@(posedge sys_clk) disable iff (rst) // R8
    sfr_wr && sfr_addr == ADDR_NEG_SEL && sfr_wdata[5:0] == NEG_REFPIN |=> neg_refpin)
    else $error("ref pin select lost");
  // Negative select keeps the low six bits of a write only
  sel_mask_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
    sfr_wr && sfr_addr == ADDR_NEG_SEL |=> neg_sel_out == $past(sfr_wdata[5:0]))
    else $error("negative select write wrong");
  // Source bit clear with no override picks the reference pin
  src_pin_a: assert property (@(posedge sys_clk) disable iff (rst) // R11
    !reference_control[REF_OVR_BIT] && !reference_control[REF_SRC_BIT] |-> ref_source == AWMR_REF_PIN)
    else $error("pin source not chosen");
  // Source bit set with no override picks the supply
  src_supply_a: assert property (@(posedge sys_clk) disable iff (rst) // R11
    !reference_control[REF_OVR_BIT] && reference_control[REF_SRC_BIT] |-> ref_source == AWMR_REF_SUPPLY)
    else $error("supply source not chosen");
  // Force bit alone turns the bias generator on
  bias_force_a: assert property (@(posedge sys_clk) disable iff (rst) // R13
    reference_control[REF_BIAS_BIT] |-> bias_enable)
    else $error("bias force ignored");

  inside_cov: cover property (@(posedge sys_clk) conv_done && inside_mode && hit);
  outside_cov: cover property (@(posedge sys_clk) conv_done && !inside_mode && hit);
  regulator_cov: cover property (@(posedge sys_clk) ref_source == AWMR_REF_REGULATOR);
  diff_cov: cover property (@(posedge sys_clk) !single_ended && conv_done);
  // Left-justified words still reach a hit
  left_cov: cover property (@(posedge sys_clk) conv_done && left_justify && hit);

endmodule : awmr_control

// File: awmr_core_model.sv
`timescale 1ns/100ps
// Converter core stand-in: a conversion ends three cycles after start
module awmr_core_model (
  // Clock
  input wire logic sys_clk,
  // Request from the bench
  input wire logic start,
  input wire logic [9:0] code,
  // Result towards the control block
  output logic conv_done,
  output logic [9:0] conv_word
);
  logic [1:0] busy; // Cycles left in the conversion
  initial begin
    busy = 2'h0;
    conv_done = 1'b0;
    conv_word = 10'h000;
  end
  // Word is valid only with the done pulse; it toggles otherwise so a stale read shows up
  always @(posedge sys_clk) begin
    busy <= start ? 2'h3 : busy - {1'b0, busy != 2'h0};
    conv_done <= (busy == 2'h1);
    conv_word <= (busy == 2'h1) ? code : ~conv_word;
  end
endmodule : awmr_core_model

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
  import awmr_pkg::*;
  // Clock, reset and register port
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  // Converter side
  logic start = 1'b0;
  logic [9:0] code = 10'h000;
  logic left_justify = 1'b0;
  logic bias_demand = 1'b0;
  logic conv_done;
  logic [9:0] conv_word;
  // Decoded outputs
  logic flag, ptemp, psup, prsv, nref, nrsv, se, bias, temp, g2x, drv;
  logic [5:0] psel, nsel;
  awmr_ref_t rsrc;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  awmr_core_model core (.sys_clk(sys_clk), .start(start), .code(code),
    .conv_done(conv_done), .conv_word(conv_word));
  awmr_control dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(1'b0), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv_done(conv_done),
    .conv_word(conv_word), .left_justify(left_justify), .bias_demand(bias_demand),
    .window_match_flag(flag), .pos_sel_out(psel), .neg_sel_out(nsel),
    .pos_temp_sensor(ptemp), .pos_supply(psup), .pos_reserved(prsv), .neg_refpin(nref),
    .neg_reserved(nrsv), .single_ended(se), .ref_source(rsrc), .bias_enable(bias),
    .temp_sensor_enable(temp), .ref_gain_2x(g2x), .ref_pin_drive(drv));
  // Verdict and end of run
  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One-cycle write strobe; ends at a negedge so outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    @(negedge sys_clk);
  endtask : wr
  // Read data is combinational, so it is judged mid-cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    @(negedge sys_clk);
    chk(sfr_rdata, exp);
  endtask : rd
  // Less-than limit first, then greater-than limit, high byte before low
  task automatic lim(input logic [15:0] lt, input logic [15:0] gt);
    wr(ADDR_LOWER_HIGH, lt[15:8]);
    wr(ADDR_LOWER_LOW, lt[7:0]);
    wr(ADDR_UPPER_HIGH, gt[15:8]);
    wr(ADDR_UPPER_LOW, gt[7:0]);
  endtask : lim
  // Clear the flag, run one conversion and judge the flag a cycle after done
  task automatic conv(input logic [9:0] w, input logic lj, input logic exp);
    int i;
    wr(ADDR_CONV_CTRL, 8'h00);
    @(posedge sys_clk);
    code <= w;
    left_justify <= lj;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (i = 0; i < 8 && conv_done !== 1'b1; i++) @(negedge sys_clk);
    chk(8'(i < 8), 8'h01);
    @(negedge sys_clk);
    chk(8'(flag), 8'(exp));
  endtask : conv
  task automatic t_reset();
    rd(ADDR_LOWER_LOW, 8'h00);
    rd(ADDR_UPPER_LOW, 8'hFF);
    rd(8'h01, 8'h00);
    wr(ADDR_LOWER_LOW, 8'hA5);
    rd(ADDR_LOWER_LOW, 8'hA5);
  endtask : t_reset
  // Inside, outside and left-justified windows, each bound of the inside and outside windows hit exactly
  task automatic t_window();
    lim(16'h0080, 16'h0040);
    conv(10'h040, 1'b0, 1'b0);
    conv(10'h041, 1'b0, 1'b1);
    conv(10'h07F, 1'b0, 1'b1);
    conv(10'h080, 1'b0, 1'b0);
    lim(16'h0040, 16'h0080);
    conv(10'h03F, 1'b0, 1'b1);
    conv(10'h040, 1'b0, 1'b0);
    conv(10'h080, 1'b0, 1'b0);
    conv(10'h081, 1'b0, 1'b1);
    lim(16'h2000, 16'h1000);
    conv(10'h041, 1'b1, 1'b1);
    conv(10'h03F, 1'b1, 1'b0);
  endtask : t_window
  task automatic t_select();
    wr(ADDR_POS_SEL, 8'hFF);
    rd(ADDR_POS_SEL, 8'h3F);
    chk(8'(prsv), 8'h01);
    wr(ADDR_POS_SEL, 8'h1E);
    chk(8'(ptemp), 8'h01);
    wr(ADDR_POS_SEL, 8'h1F);
    chk({2'h0, psel}, 8'h1F);
    chk(8'(psup), 8'h01);
    wr(ADDR_NEG_SEL, 8'hDF);
    rd(ADDR_NEG_SEL, 8'h1F);
    chk(8'(se), 8'h01);
    wr(ADDR_NEG_SEL, 8'h1E);
    chk(8'(nref), 8'h01);
    chk(8'(se), 8'h00);
    wr(ADDR_NEG_SEL, 8'h23);
    chk(8'(nrsv), 8'h01);
    chk({2'h0, nsel}, 8'h23);
  endtask : t_select
  task automatic t_ref();
    wr(ADDR_REF_CTRL, 8'hFF);
    rd(ADDR_REF_CTRL, 8'h9F);
    chk(8'(rsrc), 8'(AWMR_REF_REGULATOR));
    chk(8'(g2x), 8'h00);
    chk(8'(drv), 8'h01);
    chk(8'(temp), 8'h01);
    chk(8'(bias), 8'h01);
    wr(ADDR_REF_CTRL, 8'h08);
    chk(8'(rsrc), 8'(AWMR_REF_SUPPLY));
    chk(8'(g2x), 8'h01);
    chk(8'(drv), 8'h00);
    chk(8'(temp), 8'h00);
    chk(8'(bias), 8'h00);
    @(posedge sys_clk);
    bias_demand <= 1'b1;
    @(negedge sys_clk);
    chk(8'(bias), 8'h01);
    wr(ADDR_REF_CTRL, 8'h00);
    chk(8'(rsrc), 8'(AWMR_REF_PIN));
  endtask : t_ref
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_window();
    t_select();
    t_ref();
    stop_test();
  end
endmodule : testbench
